// [verilog/ssc_params.svh]
// offsets, field positions, reset values and encodings for the statistics counter block
`ifndef SSC_PARAMS_SVH
`define SSC_PARAMS_SVH

// register port offsets
`define SSC_OFS_CTRL 8'h79
`define SSC_OFS_ADDR_LO 8'h7A
`define SSC_OFS_DATA3 8'h80
`define SSC_OFS_DATA2 8'h81
`define SSC_OFS_DATA1 8'h82
`define SSC_OFS_DATA0 8'h83

// indirect control fields
`define SSC_CTRL_READ_BIT 4
`define SSC_CTRL_TBL_HI 3
`define SSC_CTRL_TBL_LO 2
`define SSC_CTRL_TBL_MIB 2'h3
`define SSC_CTRL_READ_MIB 8'h1C
`define SSC_CTRL_READ_DROP 8'h1D

// indirect address space
`define SSC_BANK_SPACE 2'h0
`define SSC_DROP_SPACE 2'h1
`define SSC_DROP_ENTRIES 8'h06
`define SSC_FIRST_TX_ENTRY 5'h17

// entry order inside a port bank, from the first kept entry
`define SSC_IDX_PAUSE 0
`define SSC_IDX_BCAST 1
`define SSC_IDX_MCAST 2
`define SSC_IDX_UCAST 3
`define SSC_IDX_DEFER 4
`define SSC_IDX_TOTCOL 5
`define SSC_IDX_EXCOL 6
`define SSC_IDX_ONECOL 7
`define SSC_IDX_MANYCOL 8

// data word fields
`define SSC_DATA_OVF_BIT 31
`define SSC_DATA_VALID_BIT 30

// destination kind of a sent frame
`define SSC_KIND_UCAST 2'h0
`define SSC_KIND_MCAST 2'h1
`define SSC_KIND_BCAST 2'h2

// reset values
`define SSC_RST_BYTE 8'h00
`define SSC_RST_WORD 32'h00000000

`endif

// [verilog/ssc_pkg.sv]
// types shared by the statistics counter block
package ssc_pkg;

  // indirect read sequencer
  typedef enum logic [0:0] {
    SSC_IDLE,
    SSC_FETCH
  } ssc_state_t;

endpackage

// [verilog/ssc_counters.sv]
// per-port transmit statistics and dropped-frame counters with indirect readout
//
// Function
// - count flow-control frames sent per port
// - count good bcast, mcast, ucast frames separately
// - count frames whose first attempt deferred
// - total collisions, counted in half duplex only
// - count frames abandoned after excessive collisions
// - separate one-collision and many-collision success counts
// - dropped entry: 16-bit read-only count, reset zero
// - dropped counters at 0x100-0x105, tx then rx
// - control 0x1c selects per-port counter read
// - address-low write starts the indirect read
// - data word: overflow, valid, 30-bit count
// - control 0x1d reads drop count bytes
// - per-port counters clear when read
// - drop counters keep value, no flags
// - port banks at 0x00, 0x20, 0x40
`timescale 1ns/1ps
`include "ssc_params.svh"

module ssc_counters
  import ssc_pkg::*;
#(
  parameter int NP = 3,
  parameter int NC = 9,
  parameter int CW = 30,
  parameter int DW = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // transmit events, one bit per port; destination kind two bits per port
  input wire logic [NP-1:0] tx_pause_i,
  input wire logic [NP-1:0] tx_frame_i,
  input wire logic [NP-1:0] tx_frame_err_i,
  input wire logic [2*NP-1:0] tx_dest_kind_i,
  input wire logic [NP-1:0] tx_deferred_i,
  input wire logic [NP-1:0] tx_collision_i,
  input wire logic [NP-1:0] half_duplex_i,
  input wire logic [NP-1:0] tx_excess_col_i,
  input wire logic [NP-1:0] tx_ok_one_col_i,
  input wire logic [NP-1:0] tx_ok_many_col_i,
  // dropped-frame events, one bit per port
  input wire logic [NP-1:0] tx_drop_i,
  input wire logic [NP-1:0] rx_drop_i,
  // read sequencer state
  output logic busy_o
);

  typedef struct packed {
    ssc_state_t st;
    logic [7:0] ctrl;
    logic [7:0] addr;
    logic [31:0] data;
    logic [NP-1:0][NC-1:0][CW:0] cnt;
    logic [2*NP-1:0][DW-1:0] drop;
    logic [7:0] rdata;
  } ssc_regs_t;

  ssc_regs_t q;
  ssc_regs_t d;

  logic [NP-1:0][NC-1:0] ev;
  logic [2*NP-1:0] drop_ev;
  logic [9:0] full_addr;
  logic [1:0] port_sel;
  logic [4:0] ent_sel;
  logic [3:0] idx_sel;
  logic bank_read;
  logic bank_hit;
  logic drop_read;
  logic read_req;

  ////////////////////////////////////////////////////////////////////////////
  // event decode

  // collision classes only exist on a shared medium, so full duplex masks the total, one- and many-collision counts (not excess)
  for (genvar p = 0; p < NP; p++) begin : g_ev
    logic good;
    logic [1:0] kind;
    assign good = tx_frame_i[p] & ~tx_frame_err_i[p];
    assign kind = tx_dest_kind_i[2*p +: 2];
    assign ev[p][`SSC_IDX_PAUSE] = tx_pause_i[p];
    assign ev[p][`SSC_IDX_BCAST] = good & (kind == `SSC_KIND_BCAST);
    assign ev[p][`SSC_IDX_MCAST] = good & (kind == `SSC_KIND_MCAST);
    assign ev[p][`SSC_IDX_UCAST] = good & (kind == `SSC_KIND_UCAST);
    assign ev[p][`SSC_IDX_DEFER] = tx_deferred_i[p];
    assign ev[p][`SSC_IDX_TOTCOL] = tx_collision_i[p] & half_duplex_i[p];
    assign ev[p][`SSC_IDX_EXCOL] = tx_excess_col_i[p];
    assign ev[p][`SSC_IDX_ONECOL] = tx_ok_one_col_i[p] & half_duplex_i[p];
    assign ev[p][`SSC_IDX_MANYCOL] = tx_ok_many_col_i[p] & half_duplex_i[p];
  end

  // tx drops first, then rx, matching the offset order
  assign drop_ev = {rx_drop_i, tx_drop_i};

  ////////////////////////////////////////////////////////////////////////////
  // indirect address decode

  assign full_addr = {q.ctrl[1:0], q.addr};
  assign port_sel = full_addr[6:5];
  assign ent_sel = full_addr[4:0];
  assign idx_sel = 4'(ent_sel - `SSC_FIRST_TX_ENTRY);
  assign bank_read = full_addr[9:8] == `SSC_BANK_SPACE && full_addr[7] == 1'b0;
  assign bank_hit = bank_read && 32'(port_sel) < NP && ent_sel >= `SSC_FIRST_TX_ENTRY;
  assign drop_read = full_addr[9:8] == `SSC_DROP_SPACE && full_addr[7:0] < `SSC_DROP_ENTRIES;
  // read request needs read direction and the counter table
  assign read_req = q.ctrl[`SSC_CTRL_READ_BIT] &&
                    q.ctrl[`SSC_CTRL_TBL_HI:`SSC_CTRL_TBL_LO] == `SSC_CTRL_TBL_MIB;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [CW:0] sum;
    logic [DW-1:0] dsum;
    sum = '0;
    dsum = '0;
    d = q;
    // counting; the carry out of the count sticks as overflow
    for (int p = 0; p < NP; p++) begin
      for (int k = 0; k < NC; k++) begin
        sum = {1'b0, q.cnt[p][k][CW-1:0]} + (CW+1)'(ev[p][k]);
        d.cnt[p][k] = {q.cnt[p][k][CW] | sum[CW], sum[CW-1:0]};
      end
    end
    // drop counters just wrap, software tracks it
    for (int i = 0; i < 2*NP; i++) begin
      dsum = q.drop[i] + DW'(drop_ev[i]);
      d.drop[i] = dsum;
    end
    // register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        `SSC_OFS_CTRL: begin
          d.ctrl = reg_wdata_i;
        end
        `SSC_OFS_ADDR_LO: begin
          d.addr = reg_wdata_i;
          if (read_req) begin
            // valid drops to zero until the fetch lands
            d.st = SSC_FETCH;
            d.data = `SSC_RST_WORD;
          end
        end
        default: begin
        end
      endcase
    end
    // fetch the selected entry one cycle after the trigger
    case (q.st)
      SSC_IDLE: begin
      end
      SSC_FETCH: begin
        d.st = SSC_IDLE;
        d.data = `SSC_RST_WORD;
        if (bank_hit) begin
          d.data = {q.cnt[port_sel][idx_sel][CW], 1'b1, q.cnt[port_sel][idx_sel][CW-1:0]};
          // an event in the clearing cycle is kept, not lost
          d.cnt[port_sel][idx_sel] = {1'b0, (CW)'(ev[port_sel][idx_sel])};
        end else if (bank_read) begin
          // entries not kept here read as a valid zero
          d.data[`SSC_DATA_VALID_BIT] = 1'b1;
        end else if (drop_read) begin
          d.data = {16'h0000, q.drop[full_addr[2:0]]};
        end
      end
      default: begin
        d.st = SSC_IDLE;
      end
    endcase
    // register reads, answered one cycle later
    if (reg_rd_i) begin
      case (reg_addr_i)
        `SSC_OFS_CTRL: d.rdata = q.ctrl;
        `SSC_OFS_ADDR_LO: d.rdata = q.addr;
        `SSC_OFS_DATA3: d.rdata = q.data[31:24];
        `SSC_OFS_DATA2: d.rdata = q.data[23:16];
        `SSC_OFS_DATA1: d.rdata = q.data[15:8];
        `SSC_OFS_DATA0: d.rdata = q.data[7:0];
        default: d.rdata = `SSC_RST_BYTE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign reg_rdata_o = q.rdata;
  assign busy_o = q.st == SSC_FETCH;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_trigger;
    reg_wr_i && reg_addr_i == `SSC_OFS_ADDR_LO && read_req;
  endsequence

  sequence s_fetch_done;
    q.st == SSC_FETCH ##1 q.st == SSC_IDLE;
  endsequence

  // trigger leads to one fetch cycle then idle
  read_start_a: assert property (s_trigger |=> s_fetch_done)
    else $error("indirect read did not run a single fetch cycle");

  // valid is low while the fetch is pending
  valid_pending_a: assert property (s_trigger |=> !q.data[`SSC_DATA_VALID_BIT])
    else $error("valid flag set before fetch completed");

  // bank read ends with the valid flag set
  valid_after_a: assert property (q.st == SSC_FETCH && bank_read |=> q.data[`SSC_DATA_VALID_BIT])
    else $error("valid flag missing after counter fetch");

  // read of a kept counter clears it, except for a same-cycle event
  clear_on_read_a: assert property (
    q.st == SSC_FETCH && bank_hit && !ev[port_sel][idx_sel]
    |=> q.cnt[$past(port_sel)][$past(idx_sel)] == '0)
    else $error("counter not cleared by read");

  // fetched word carries the old count and overflow
  fetch_value_a: assert property (
    q.st == SSC_FETCH && bank_hit
    |=> q.data[CW-1:0] == $past(q.cnt[port_sel][idx_sel][CW-1:0])
        && q.data[`SSC_DATA_OVF_BIT] == $past(q.cnt[port_sel][idx_sel][CW]))
    else $error("fetched word does not match counter");

  // drop read leaves the counter and has no flags
  drop_keep_a: assert property (
    q.st == SSC_FETCH && drop_read && !drop_ev[full_addr[2:0]]
    |=> q.data[31:16] == 16'h0000 && q.drop[$past(full_addr[2:0])] == q.data[DW-1:0])
    else $error("drop counter changed or flagged by read");

  // control write is held in the control register from the next cycle
  ctrl_store_a: assert property (
    reg_wr_i && reg_addr_i == `SSC_OFS_CTRL |=> q.ctrl == $past(reg_wdata_i))
    else $error("indirect control byte not stored");

  for (genvar p = 0; p < NP; p++) begin : g_chk
    // full duplex keeps the total collision count still
    coll_duplex_a: assert property (
      !half_duplex_i[p] && q.st == SSC_IDLE
      |=> q.cnt[p][`SSC_IDX_TOTCOL] == $past(q.cnt[p][`SSC_IDX_TOTCOL]))
      else $error("collision counted in full duplex");

    // broadcast frame leaves multicast count alone
    bcast_only_a: assert property (
      ev[p][`SSC_IDX_BCAST] && q.st == SSC_IDLE
      |=> q.cnt[p][`SSC_IDX_MCAST] == $past(q.cnt[p][`SSC_IDX_MCAST])
          && q.cnt[p][`SSC_IDX_BCAST][CW-1:0] == $past(q.cnt[p][`SSC_IDX_BCAST][CW-1:0]) + 1'b1)
      else $error("broadcast frame miscounted");

    // deferral adds exactly one
    defer_count_a: assert property (
      ev[p][`SSC_IDX_DEFER] && q.st == SSC_IDLE
      |=> q.cnt[p][`SSC_IDX_DEFER][CW-1:0] == $past(q.cnt[p][`SSC_IDX_DEFER][CW-1:0]) + 1'b1)
      else $error("deferral not counted");

    // wrap sets the sticky overflow
    wrap_ovf_a: assert property (
      ev[p][`SSC_IDX_PAUSE] && &q.cnt[p][`SSC_IDX_PAUSE][CW-1:0] && q.st == SSC_IDLE
      |=> q.cnt[p][`SSC_IDX_PAUSE][CW] && q.cnt[p][`SSC_IDX_PAUSE][CW-1:0] == '0)
      else $error("wrap did not set overflow");
  end

endmodule

// [verification/ssc_host.sv]
// host model driving the register port of the statistics counter block
`timescale 1ns/1ps

module ssc_host (
  // clock
  input wire logic clk_i,
  // register port, host side
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i
);
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end

  // one write; idle address and data are inverted so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    reg_wr_o = 1'b1;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(posedge clk_i);
    #1;
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask

  // one read; data is registered, so it is taken one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    reg_rd_o = 1'b1;
    reg_addr_o = a;
    @(posedge clk_i);
    #1;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
  endtask

  // indirect read of a 32-bit word; control byte also carries the high address bits
  task automatic rd_ind(input logic [7:0] ctrl, input logic [7:0] lo, output logic [31:0] w);
    int tries;
    logic [7:0] b;
    wr(8'h79, ctrl);
    wr(8'h7A, lo);
    tries = 0;
    do begin
      for (int i = 0; i < 4; i++) begin
        rd(8'h80 + 8'(i), b);
        w = {w[23:0], b};
      end
      tries++;
    end while (ctrl == 8'h1C && w[30] !== 1'b1 && tries < 4);
  endtask
endmodule

// [verification/tb_switch_statistics_counter_readout.sv]
// testbench: counter events per port and indirect readout through the host model
`timescale 1ns/1ps

module tb_switch_statistics_counter_readout;
  logic clk_i, rst_i, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [2:0] pause, frame, ferr, defer, col, hd, exc, one, many, tdrop, rdrop;
  logic [5:0] kind;
  logic [31:0] w;
  logic busy;
  int n_mismatch, checked;

  ////////////////////////////////////////////////////////////////////////
  // clock, design and host
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  ssc_counters u_dut (.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .tx_pause_i(pause),
    .tx_frame_i(frame), .tx_frame_err_i(ferr), .tx_dest_kind_i(kind), .tx_deferred_i(defer),
    .tx_collision_i(col), .half_duplex_i(hd), .tx_excess_col_i(exc), .tx_ok_one_col_i(one),
    .tx_ok_many_col_i(many), .tx_drop_i(tdrop), .rx_drop_i(rdrop), .busy_o(busy));

  ssc_host u_host (.clk_i(clk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata));

  ////////////////////////////////////////////////////////////////////////
  // compare, verdict and event tasks
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // n one-cycle events of class k on port p; 11 is an errored frame
  task automatic ev(input int k, input int p, input int n);
    repeat (n) begin
      @(posedge clk_i);
      #1;
      case (k)
        0: pause[p] = 1'b1;
        1, 2, 3, 11: frame[p] = 1'b1;
        4: defer[p] = 1'b1;
        5: col[p] = 1'b1;
        6: exc[p] = 1'b1;
        7: one[p] = 1'b1;
        8: many[p] = 1'b1;
        9: tdrop[p] = 1'b1;
        default: rdrop[p] = 1'b1;
      endcase
      ferr[p] = (k == 11);
      @(posedge clk_i);
      #1;
      {pause, frame, ferr, defer, col, exc, one, many, tdrop, rdrop} = '0;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {pause, frame, ferr, defer, col, exc, one, many, tdrop, rdrop} = '0;
    hd = 3'h7;
    kind = 6'h3F;
    n_mismatch = 0;
    checked = 0;
    rst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    u_host.rd_ind(8'h1D, 8'h00, w);
    chk("drop_reset", 32'h00000000, w);
    for (int p = 0; p < 3; p++) begin
      for (int k = 0; k < 9; k++) begin
        // kinds: ucast 0, mcast 1, bcast 2; errored frames must not count
        kind[2*p +: 2] = (k == 1) ? 2'h2 : (k == 2) ? 2'h1 : 2'h0;
        ev(k, p, k + p + 1);
        if (k >= 1 && k <= 3) ev(11, p, 2);
        if (k == 5) begin
          hd[p] = 1'b0;
          ev(5, p, 3);
          hd[p] = 1'b1;
        end
        u_host.rd_ind(8'h1C, 8'(32 * p + 23 + k), w);
        chk("port_count", {2'b01, 30'(k + p + 1)}, w);
        u_host.rd_ind(8'h1C, 8'(32 * p + 23 + k), w);
        chk("cleared", 32'h40000000, w);
      end
    end
    for (int q = 0; q < 6; q++) begin
      ev(q < 3 ? 9 : 10, q % 3, q + 1);
      repeat (2) begin
        u_host.rd_ind(8'h1D, 8'(q), w);
        chk("drop_count", 32'(q + 1), w);
      end
    end
    // entries below the kept range answer as a valid zero
    u_host.rd_ind(8'h1C, 8'h05, w);
    chk("unkept_entry", 32'h40000000, w);
    // fetch flag: high for the one cycle after the trigger write, then low
    u_host.wr(8'h79, 8'h1C);
    u_host.wr(8'h7A, 8'h17);
    chk("busy_fetch", 32'(busy), 32'h00000001);
    @(posedge clk_i);
    #1;
    chk("busy_idle", 32'(busy), 32'h00000000);
    // every counter was read back long before it could wrap
    wrap_up();
  end

  // watchdog well beyond the roughly 1250 cycles the sequence needs
  initial begin
    #(25 * 20000);
    n_mismatch++;
    wrap_up();
  end
endmodule
